// *** src/srw_pkg.sv ***
package srw_pkg;

  // ---------------------------------------------------------------------------
  // Instruction fields
  // ---------------------------------------------------------------------------
  localparam int          XLEN       = 32;
  localparam logic [1:0]  OP_FMT     = 2'h2;
  localparam logic [5:0]  OP3_ASR    = 6'h30;
  localparam logic [5:0]  OP3_PSR    = 6'h31;
  localparam logic [5:0]  OP3_WIM    = 6'h32;
  localparam logic [5:0]  OP3_TBR    = 6'h33;
  localparam int          FMT_HI     = 31;
  localparam int          FMT_LO     = 30;
  localparam int          RD_HI      = 29;
  localparam int          RD_LO      = 25;
  localparam int          OP3_HI     = 24;
  localparam int          OP3_LO     = 19;
  localparam int          SEL_BIT    = 13;
  localparam int          IMM_HI     = 12;
  localparam int          IMM_W      = 13;

  // ---------------------------------------------------------------------------
  // Ancillary destination ranges
  // ---------------------------------------------------------------------------
  localparam logic [4:0]  ASR_Y_MAX    = 5'h0f;
  localparam logic [4:0]  ASR_USER_MAX = 5'h17;
  localparam logic [4:0]  ASR_PRIV_MAX = 5'h1d;
  localparam logic [4:0]  ASR_TEST_CONTROL_REGISTER     = 5'h1e;
  localparam logic [4:0]  ASR_ICCR     = 5'h1f;

  // ---------------------------------------------------------------------------
  // State register layouts and reset values
  // ---------------------------------------------------------------------------
  localparam int          PSR_PRIV_BIT  = 7;
  localparam int          PSR_CWP_HI    = 4;
  localparam int          PSR_CWP_LO    = 0;
  localparam int          PSR_ID_LO     = 24;
  localparam logic [31:0] PSR_WR_MASK   = 32'h00f0_3fff;
  localparam logic [31:0] PSR_RESET     = 32'h0000_0080;
  localparam logic [31:0] TBR_TBA_MASK  = 32'hffff_f000;
  localparam logic [31:0] STATE_RESET   = 32'h0000_0000;

  // ---------------------------------------------------------------------------
  // Bus map
  // ---------------------------------------------------------------------------
  localparam int          ADDR_W      = 8;
  localparam logic [7:0]  ADDR_CTRL   = 8'h00;
  localparam logic [7:0]  ADDR_STATUS = 8'h04;
  localparam logic [7:0]  ADDR_PSR    = 8'h08;
  localparam logic [7:0]  ADDR_TBR    = 8'h0c;
  localparam logic [7:0]  ADDR_WIM    = 8'h10;
  localparam logic [7:0]  ADDR_Y      = 8'h14;
  localparam logic [7:0]  ADDR_TEST_CONTROL_REGISTER   = 8'h18;
  localparam logic [7:0]  ADDR_ICCR   = 8'h1c;
  localparam int          CTRL_EN_BIT = 0;
  localparam logic [31:0] CTRL_RESET  = 32'h0000_0001;
  localparam logic [1:0]  SPLIT_SPAN  = 2'h3;

endpackage

// *** src/state_register_write_unit.sv ***
// Overview of operation
// - Each state write stores first source XOR second operand into its target.
// - Selector 0 takes second source register; 1 takes sign-extended 13-bit immediate.
// - Ancillary destination 0 to 15 writes the product high half register.
// - Ancillary destination 16 to 23 raises illegal instruction, writes nothing.
// - Destination 24 to 29: privileged gives illegal, user gives privilege violation.
// - Destination 30 writes test control when privileged, else privilege violation.
// - Destination 31 writes cache control when privileged, else privilege violation.
// - Any state write forces packet splitting for the next three instructions.
// - State write changes only writable processor state subfields.
// - Unimplemented window pointer result raises illegal instruction, state unchanged.
// - Fields read within three instructions may show old or new value.
// - A trap handler after a state write reads the new value.
// - Lowering mask while enabling traps may take an interrupt at old level.
// - Trap base write changes only the trap table base field.
// - Traps soon after may vector with either base; handler reads new one.
// - Window mask write changes only implemented writable mask bits.
// - Window push, pop, return soon after may use old or new mask.
// - A trap handler after a window mask write reads the new mask.
// - Window mask write: format 10, op3 110010, fields at documented positions.
// - Product high half writes are delayed; nearby readers see old or new.
`timescale 1ns/1ps
`default_nettype none

module state_register_write_unit
  import srw_pkg::*;
#(
  parameter int          NWIN     = 8,        // Implemented register windows
  parameter logic [7:0]  IMPL_VER = 8'h5a     // Arbitrary identity value
) (
  input  wire logic             hclk,           // Core and bus clock
  input  wire logic             hresetn,        // Asynchronous reset, active low
  input  wire logic             hsel,           // Slave select
  input  wire logic [31:0]      haddr,          // Byte address
  input  wire logic [1:0]       htrans,         // Transfer type
  input  wire logic             hwrite,         // Write when high
  input  wire logic [2:0]       hsize,          // Transfer size
  input  wire logic [31:0]      hwdata,         // Write data
  input  wire logic             hready,         // Bus ready in
  output logic      [31:0]      hrdata,         // Read data
  output logic                  hreadyout,      // Slave ready
  output logic                  hresp,          // Always OKAY
  input  wire logic             instr_valid,    // Instruction present this cycle
  input  wire logic [31:0]      instr_word,     // Instruction word
  input  wire logic [31:0]      src1_data,      // First source register value
  input  wire logic [31:0]      src2_data,      // Second source register value
  output logic                  instr_done,     // Pulse: instruction retired
  output logic                  illegal_trap,   // Pulse: illegal instruction trap
  output logic                  priv_trap,      // Pulse: privilege violation trap
  output logic                  split_packet,   // Level: issue singly
  output logic      [31:0]      psr_out,        // Processor state register
  output logic      [31:0]      tbr_out,        // Trap base register
  output logic      [31:0]      wim_out,        // Window invalid mask
  output logic      [31:0]      y_out,          // Product high half
  output logic      [31:0]      test_control_register_out,       // Test control register
  output logic      [31:0]      iccr_out        // Cache control register
);

  // ---------------------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------------------
  if (NWIN < 2 || NWIN > 32) begin : g_bad_nwin
    $error("NWIN must lie between 2 and 32");
  end

  localparam logic [31:0] WIM_MASK = (NWIN == 32) ? 32'hffff_ffff :
                                     ((32'h1 << NWIN) - 32'h1);
  localparam logic [4:0]  CWP_MAX  = 5'(NWIN - 1);

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  function automatic logic is_op(input logic [31:0] w, input logic [5:0] op3);
    is_op = (w[FMT_HI:FMT_LO] == OP_FMT) && (w[OP3_HI:OP3_LO] == op3);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [31:0] mask);
    merge = (old_v & ~mask) | (new_v & mask);
  endfunction

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  logic [31:0] psr_q;
  logic [31:0] tbr_q;
  logic [31:0] wim_q;
  logic [31:0] y_q;
  logic [31:0] test_control_register_q;
  logic [31:0] iccr_q;
  logic [31:0] ctrl_q;
  logic [1:0]  split_cnt_q;
  logic        split_q;
  logic        done_q;
  logic        ill_q;
  logic        prv_q;
  logic        last_ill_q;
  logic        last_prv_q;
  logic        dph_q;
  logic        dph_wr_q;
  logic [7:0]  dph_addr_q;
  logic [31:0] hrdata_q;
  logic        hreadyout_q;

  // ---------------------------------------------------------------------------
  // Decode and operand
  // ---------------------------------------------------------------------------
  logic        take;
  logic        op_asr;
  logic        op_psr;
  logic        op_wim;
  logic        op_tbr;
  logic        any_wr;
  logic        priv;
  logic [4:0]  dest;
  logic [31:0] operand_b;
  logic [31:0] result;
  logic        wr_y;
  logic        wr_test_control_register;
  logic        wr_iccr;
  logic        wr_psr;
  logic        wr_tbr;
  logic        wr_wim;
  logic        raise_ill;
  logic        raise_prv;

  assign take   = instr_valid && ctrl_q[CTRL_EN_BIT];
  assign op_asr = is_op(instr_word, OP3_ASR);
  assign op_psr = is_op(instr_word, OP3_PSR);
  assign op_wim = is_op(instr_word, OP3_WIM);
  assign op_tbr = is_op(instr_word, OP3_TBR);
  assign any_wr = op_asr || op_psr || op_wim || op_tbr;
  assign priv   = psr_q[PSR_PRIV_BIT];
  assign dest   = instr_word[RD_HI:RD_LO];

  // Immediate is sign-extended from bit 12 to the full word.
  assign operand_b = instr_word[SEL_BIT] ?
                     {{(XLEN - IMM_W){instr_word[IMM_HI]}}, instr_word[IMM_HI:0]} :
                     src2_data;
  assign result    = src1_data ^ operand_b;

  // Privilege is checked before the window pointer, so a user-mode write to
  // state, trap base or window mask always reports the privilege violation.
  always_comb begin
    wr_y      = 1'b0;
    wr_test_control_register   = 1'b0;
    wr_iccr   = 1'b0;
    wr_psr    = 1'b0;
    wr_tbr    = 1'b0;
    wr_wim    = 1'b0;
    raise_ill = 1'b0;
    raise_prv = 1'b0;
    if (take && op_asr) begin
      if (dest <= ASR_Y_MAX) begin
        wr_y = 1'b1;
      end else if (dest <= ASR_USER_MAX) begin
        raise_ill = 1'b1;
      end else if (dest <= ASR_PRIV_MAX) begin
        raise_ill = priv;
        raise_prv = !priv;
      end else if (dest == ASR_TEST_CONTROL_REGISTER) begin
        wr_test_control_register   = priv;
        raise_prv = !priv;
      end else begin
        wr_iccr   = priv;
        raise_prv = !priv;
      end
    end else if (take && (op_psr || op_tbr || op_wim)) begin
      if (!priv) begin
        raise_prv = 1'b1;
      end else if (op_psr && result[PSR_CWP_HI:PSR_CWP_LO] > CWP_MAX) begin
        raise_ill = 1'b1;
      end else begin
        wr_psr = op_psr;
        wr_tbr = op_tbr;
        wr_wim = op_wim;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Architectural registers
  // ---------------------------------------------------------------------------
  // Every write lands at the edge that takes the instruction. That is one of
  // the two values allowed in the delay shadow, and it guarantees that a
  // handler entered from the shadow reads back the new contents.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      psr_q <= PSR_RESET;
    end else if (wr_psr) begin
      psr_q <= merge(psr_q, result, PSR_WR_MASK);
    end
  end

  // Mask level and trap enable change in the same edge, so the interrupt
  // logic never sees traps enabled with a stale level from this block.
  // Software is still expected to stage the two writes.

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tbr_q <= STATE_RESET;
    end else if (wr_tbr) begin
      tbr_q <= merge(tbr_q, result, TBR_TBA_MASK);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wim_q <= STATE_RESET;
    end else if (wr_wim) begin
      wim_q <= merge(wim_q, result, WIM_MASK);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      y_q <= STATE_RESET;
    end else if (wr_y) begin
      y_q <= result;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      test_control_register_q <= STATE_RESET;
      iccr_q <= STATE_RESET;
    end else begin
      if (wr_test_control_register) begin
        test_control_register_q <= result;
      end
      if (wr_iccr) begin
        iccr_q <= result;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Packet splitting
  // ---------------------------------------------------------------------------
  // Counts the instructions that follow a state write; a new state write
  // inside the span restarts it, trapped or not.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      split_cnt_q <= 2'h0;
      split_q     <= 1'b0;
    end else if (take) begin
      if (any_wr) begin
        split_cnt_q <= SPLIT_SPAN;
        split_q     <= 1'b1;
      end else if (split_cnt_q != 2'h0) begin
        split_cnt_q <= split_cnt_q - 2'h1;
        split_q     <= (split_cnt_q != 2'h1);
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Trap and retire pulses
  // ---------------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      done_q     <= 1'b0;
      ill_q      <= 1'b0;
      prv_q      <= 1'b0;
      last_ill_q <= 1'b0;
      last_prv_q <= 1'b0;
    end else begin
      done_q <= take;
      ill_q  <= raise_ill;
      prv_q  <= raise_prv;
      if (take && any_wr) begin
        last_ill_q <= raise_ill;
        last_prv_q <= raise_prv;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Bus slave
  // ---------------------------------------------------------------------------
  logic        aph;
  logic [7:0]  aph_addr;
  logic [31:0] rd_mux;

  assign aph      = hsel && htrans[1] && hready;
  assign aph_addr = haddr[ADDR_W-1:0];

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (aph_addr)
      ADDR_CTRL:   rd_mux = ctrl_q;
      ADDR_STATUS: rd_mux = {28'h000_0000, split_cnt_q, last_prv_q, last_ill_q};
      ADDR_PSR:    rd_mux = {IMPL_VER, psr_q[PSR_ID_LO-1:0]};
      ADDR_TBR:    rd_mux = tbr_q;
      ADDR_WIM:    rd_mux = wim_q;
      ADDR_Y:      rd_mux = y_q;
      ADDR_TEST_CONTROL_REGISTER:   rd_mux = test_control_register_q;
      ADDR_ICCR:   rd_mux = iccr_q;
      default:     rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_q      <= 1'b0;
      dph_wr_q   <= 1'b0;
      dph_addr_q <= 8'h00;
    end else if (hready) begin
      dph_q      <= aph;
      dph_wr_q   <= aph && hwrite;
      dph_addr_q <= aph_addr;
    end
  end

  // Read data is registered in the address phase, so a read never waits but
  // shows the state as it stood at the address edge.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= 32'h0000_0000;
    end else if (aph && !hwrite) begin
      hrdata_q <= rd_mux;
    end
  end

  // Only the control word is writable; other offsets ignore writes.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= CTRL_RESET;
    end else if (dph_q && dph_wr_q && dph_addr_q == ADDR_CTRL) begin
      ctrl_q <= {31'h0000_0000, hwdata[CTRL_EN_BIT]};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_q <= 1'b0;
    end else begin
      hreadyout_q <= 1'b1;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign hrdata       = hrdata_q;
  assign hreadyout    = hreadyout_q;
  assign hresp        = 1'b0;
  assign instr_done   = done_q;
  assign illegal_trap = ill_q;
  assign priv_trap    = prv_q;
  assign split_packet = split_q;
  assign psr_out      = {IMPL_VER, psr_q[PSR_ID_LO-1:0]};
  assign tbr_out      = tbr_q;
  assign wim_out      = wim_q;
  assign y_out        = y_q;
  assign test_control_register_out     = test_control_register_q;
  assign iccr_out     = iccr_q;

endmodule // state_register_write_unit

`default_nettype wire

// *** tb/srw_chk.sv ***
`timescale 1ns/1ps
`default_nettype none

module srw_chk
  import srw_pkg::*;
#(
  parameter int NWIN = 8         // Implemented register windows
) (
  input wire logic        hclk,         // Core clock
  input wire logic        hresetn,      // Reset, active low
  input wire logic [31:0] instr_word,   // Instruction word
  input wire logic [31:0] src1_data,    // First operand
  input wire logic [31:0] src2_data,    // Second operand
  input wire logic        instr_done,   // Retire pulse
  input wire logic        illegal_trap, // Illegal pulse
  input wire logic        priv_trap,    // Privilege pulse
  input wire logic        split_packet, // Issue singly
  input wire logic [31:0] psr_out,      // State register
  input wire logic [31:0] tbr_out,      // Trap base
  input wire logic [31:0] wim_out,      // Window mask
  input wire logic [31:0] y_out,        // Product high half
  input wire logic [31:0] test_control_register_out,     // Test control
  input wire logic [31:0] iccr_out      // Cache control
);
  // ---------------------------------------------------------------------------
  // The taken instruction is kept so it can be judged when its result appears.
  // ---------------------------------------------------------------------------
  logic [31:0] w_q;
  logic [31:0] a_q;
  logic [31:0] b_q;
  logic        s_q;
  always_ff @(posedge hclk) begin
    w_q <= instr_word;
    a_q <= src1_data;
    b_q <= src2_data;
    s_q <= psr_out[PSR_PRIV_BIT];
  end
  wire logic [31:0] res = a_q ^ (w_q[SEL_BIT] ? {{19{w_q[IMM_HI]}}, w_q[IMM_HI:0]} : b_q);
  wire logic [4:0]  rd  = w_q[RD_HI:RD_LO];
  wire logic        fmt = w_q[FMT_HI:FMT_LO] == OP_FMT;
  wire logic        asr = fmt && w_q[OP3_HI:OP3_LO] == OP3_ASR;
  wire logic        psr = fmt && w_q[OP3_HI:OP3_LO] == OP3_PSR;
  wire logic        tbr = fmt && w_q[OP3_HI:OP3_LO] == OP3_TBR;
  wire logic        wim = fmt && w_q[OP3_HI:OP3_LO] == OP3_WIM;
  wire logic [31:0] wmask = (NWIN == 32) ? 32'hffff_ffff : ((32'h1 << NWIN) - 32'h1);

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence taken_s;
    instr_done;
  endsequence
  sequence wr_s;
    taken_s ##0 (asr || psr || tbr || wim);
  endsequence

  y_write_a: assert property (
    taken_s ##0 (asr && rd <= ASR_Y_MAX) |-> y_out == res && !illegal_trap && !priv_trap)
    else $error("product high write wrong");
  user_unimpl_a: assert property (
    taken_s ##0 (asr && rd > ASR_Y_MAX && rd <= ASR_USER_MAX)
    |-> illegal_trap && !priv_trap && $stable(y_out)) else $error("user slot not refused");
  priv_unimpl_a: assert property (
    taken_s ##0 (asr && rd > ASR_USER_MAX && rd <= ASR_PRIV_MAX)
    |-> illegal_trap == s_q && priv_trap == !s_q) else $error("privileged slot trap wrong");
  test_control_register_write_a: assert property (
    taken_s ##0 (asr && rd == ASR_TEST_CONTROL_REGISTER)
    |-> (s_q ? test_control_register_out == res : priv_trap && $stable(test_control_register_out))) else $error("test write wrong");
  iccr_write_a: assert property (
    taken_s ##0 (asr && rd == ASR_ICCR)
    |-> (s_q ? iccr_out == res : priv_trap && $stable(iccr_out))) else $error("cache write wrong");
  split_set_a: assert property (
    wr_s |-> split_packet) else $error("no packet split after write");
  psr_write_a: assert property (
    taken_s ##0 (psr && s_q && res[4:0] < NWIN)
    |-> psr_out == ($past(psr_out) & ~PSR_WR_MASK | res & PSR_WR_MASK)) else $error("state wrong");
  cwp_bad_a: assert property (
    taken_s ##0 (psr && s_q && res[4:0] >= NWIN)
    |-> illegal_trap && $stable(psr_out)) else $error("bad window accepted");
  tbr_write_a: assert property (
    taken_s ##0 (tbr && s_q)
    |-> tbr_out == ($past(tbr_out) & ~TBR_TBA_MASK | res & TBR_TBA_MASK))
    else $error("base wrong");
  wim_write_a: assert property (
    taken_s ##0 (wim && s_q)
    |-> wim_out == ($past(wim_out) & ~wmask | res & wmask)) else $error("window mask wrong");
  user_priv_a: assert property (
    taken_s ##0 ((psr || tbr || wim) && !s_q) |-> priv_trap && $stable(psr_out)
    && $stable(tbr_out) && $stable(wim_out)) else $error("user write not refused");
endmodule // srw_chk

bind state_register_write_unit srw_chk #(.NWIN(NWIN)) i_srw_chk (
  .hclk(hclk), .hresetn(hresetn), .instr_word(instr_word), .src1_data(src1_data),
  .src2_data(src2_data), .instr_done(instr_done), .illegal_trap(illegal_trap),
  .priv_trap(priv_trap), .split_packet(split_packet), .psr_out(psr_out), .tbr_out(tbr_out),
  .wim_out(wim_out), .y_out(y_out), .test_control_register_out(test_control_register_out), .iccr_out(iccr_out));

`default_nettype wire

// *** tb/instr_stream.sv ***
`timescale 1ns/1ps
`default_nettype none

module instr_stream (
  input  wire logic        hclk,         // Core clock
  input  wire logic        illegal_trap, // Illegal pulse
  input  wire logic        priv_trap,    // Privilege pulse
  output logic             instr_valid,  // Instruction present
  output logic      [31:0] instr_word,   // Instruction word
  output logic      [31:0] src1_data,    // First operand
  output logic      [31:0] src2_data,    // Second operand
  output logic      [7:0]  trap_count    // Traps taken
);
  initial begin
    instr_valid = 1'b0;
    instr_word = 32'h0;
    src1_data = 32'h0;
    src2_data = 32'h0;
    trap_count = 8'h0;
  end
  always @(posedge hclk) begin
    if (illegal_trap || priv_trap) begin
      trap_count <= trap_count + 8'h01;
    end
  end
  // Released lines show the inverse so a stale value can never be mistaken for live.
  task automatic issue(input logic [31:0] w, input logic [31:0] a, input logic [31:0] b);
    @(posedge hclk);
    instr_valid <= 1'b1;
    instr_word <= w;
    src1_data <= a;
    src2_data <= b;
    @(posedge hclk);
    instr_valid <= 1'b0;
    instr_word <= ~w;
    src1_data <= ~a;
    src2_data <= ~b;
  endtask
endmodule // instr_stream

`default_nettype wire

// *** tb/state_register_write_unit_test.sv ***
`timescale 1ns/1ps
`default_nettype none

module state_register_write_unit_test
  import srw_pkg::*;
;
  localparam logic [7:0] ID = 8'h3c; // Arbitrary identity value.
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  wire logic [31:0] hrdata, psr, tbr, wim, y, dg, ic, iw, s1, s2;
  wire logic        rdy, hresp, done, ill, prv, split, iv;
  wire logic [7:0]  tc;
  int          failures = 0;
  int          checks_done = 0;
  int          ntrap = 0;
  logic [31:0] rd_v, r, pm, tm, wm;
  logic [31:0] ym = 32'h0;
  logic [31:0] dm = 32'h0;
  logic [31:0] im = 32'h0;

  state_register_write_unit #(.NWIN(8), .IMPL_VER(ID)) i_state_register_write_unit (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(rdy), .hrdata(hrdata),
    .hreadyout(rdy), .hresp(hresp), .instr_valid(iv), .instr_word(iw), .src1_data(s1),
    .src2_data(s2), .instr_done(done), .illegal_trap(ill), .priv_trap(prv),
    .split_packet(split), .psr_out(psr), .tbr_out(tbr), .wim_out(wim), .y_out(y),
    .test_control_register_out(dg), .iccr_out(ic));
  instr_stream i_instr_stream (.hclk(hclk), .illegal_trap(ill), .priv_trap(prv),
    .instr_valid(iv), .instr_word(iw), .src1_data(s1), .src2_data(s2), .trap_count(tc));

  always #2.5 hclk = ~hclk;

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (rdy !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (rdy !== 1'b1);
    rd_v = hrdata;
    hsel <= 1'b0;
  endtask
  function automatic logic [31:0] ins(input logic [5:0] op3, input logic [4:0] d, input logic i);
    return {OP_FMT, d, op3, 5'h0, i, 13'h1a5c};
  endfunction
  task automatic exec(input logic [31:0] w, input logic [31:0] a, input logic [31:0] b,
                      input logic [1:0] tr);
    r = a ^ (w[SEL_BIT] ? {{19{w[IMM_HI]}}, w[IMM_HI:0]} : b);
    i_instr_stream.issue(w, a, b);
    #1;
    check("done", done, 32'h1);
    check("trap", {ill, prv}, tr);
    ntrap += (tr != 2'h0);
  endtask
  task automatic give_verdict();
    $display("checks_done %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    #100000;
    failures++;
    give_verdict();
  end

  initial begin
    repeat (10) @(posedge hclk);
    pm = {ID, 24'h000080};
    check("psr reset", psr, pm);
    check("others reset", tbr | wim | y | dg | ic, 32'h0);
    hresetn <= 1'b1;
    bus(1'b0, 8'h40, 32'h0);
    check("unmapped", rd_v, 32'h0);
    // -------------------------------------------------------------------------
    // Every ancillary destination while privileged.
    // -------------------------------------------------------------------------
    for (int k = 0; k < 32; k++) begin
      exec(ins(OP3_ASR, k[4:0], k[0]), 32'h1234_5678 ^ 32'(k), 32'h0f0f_a5a5 + 32'(k),
           (k > 15 && k < 30) ? 2'h2 : 2'h0);
      if (k < 16) ym = r;
      if (k == 30) dm = r;
      if (k == 31) im = r;
      check("y", y, ym);
      check("test_control_register", dg, dm);
      check("iccr", ic, im);
    end
    check("split", split, 32'h1);
    for (int k = 0; k < 3; k++) begin
      exec(ins(6'h03, 5'h1, 1'b0), 32'h1, 32'h2, 2'h0);
      check("split", split, 32'(k < 2));
    end
    bus(1'b1, ADDR_CTRL, 32'h0);
    i_instr_stream.issue(ins(OP3_ASR, 5'h0, 1'b1), 32'h1, 32'h0);
    #1;
    check("held done", done, 32'h0);
    check("held y", y, ym);
    bus(1'b1, ADDR_CTRL, 32'h1);
    // -------------------------------------------------------------------------
    // Level first with traps off, then traps on at the same level.
    // -------------------------------------------------------------------------
    for (int j = 0; j < 3; j++) begin
      exec(ins(OP3_PSR, 5'h0, 1'b0), 32'h0f3c_0683 | (32'(j) << 5), 32'h0, 2'h0);
      pm = pm & ~PSR_WR_MASK | r & PSR_WR_MASK;
      check("psr", psr, pm);
    end
    exec(ins(OP3_PSR, 5'h0, 1'b0), 32'h0000_009f, 32'h0, 2'h2);
    check("psr kept", psr, pm);
    exec(ins(OP3_TBR, 5'h0, 1'b1), 32'hdead_beef, 32'h0, 2'h0);
    tm = r & TBR_TBA_MASK;
    check("tbr", tbr, tm);
    exec(ins(OP3_WIM, 5'h0, 1'b0), 32'h1234_56c3, 32'h0000_0f00, 2'h0);
    wm = r & 32'h0000_00ff;
    check("wim", wim, wm);
    bus(1'b0, ADDR_TBR, 32'h0);
    check("tbr read", rd_v, tm);
    bus(1'b0, ADDR_WIM, 32'h0);
    check("wim read", rd_v, wm);
    bus(1'b1, ADDR_PSR, 32'hffff_ffff);
    bus(1'b0, ADDR_PSR, 32'h0);
    check("psr read", rd_v, pm);
    // -------------------------------------------------------------------------
    // Drop to user level, then state, window mask, trap base and destinations 24, 30, 31 must be refused; 16 traps illegal.
    // -------------------------------------------------------------------------
    exec(ins(OP3_PSR, 5'h0, 1'b0), 32'h0000_0003, 32'h0, 2'h0);
    pm = pm & ~PSR_WR_MASK | r & PSR_WR_MASK;
    for (int k = 0; k < 7; k++) begin
      exec(ins(k < 3 ? 6'(OP3_PSR + 6'(k)) : OP3_ASR,
               k == 3 ? 5'd24 : k == 4 ? 5'd30 : k == 5 ? 5'd31 : 5'd16, 1'b0),
           32'h5555_aaaa, 32'h0, k == 6 ? 2'h2 : 2'h1);
      check("psr", psr, pm);
      check("tbr", tbr, tm);
      check("wim", wim, wm);
      check("test_control_register", dg, dm);
      check("iccr", ic, im);
    end
    bus(1'b0, ADDR_STATUS, 32'h0);
    check("status", rd_v, 32'h0000_000d);
    check("traps", {24'h0, tc}, 32'(ntrap));
    give_verdict();
  end
endmodule // state_register_write_unit_test

`default_nettype wire
